// ---- hdl/rtp_defines.svh ----
/*
  offsets, field positions, reset values of the real-time output port.
  assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef RTP_DEFINES_SVH
`define RTP_DEFINES_SVH

// ---------------------------------------------------------------
// special function register offsets
// ---------------------------------------------------------------
`define RTP_OFF_LATCH 3'h0
`define RTP_OFF_DIR 3'h1
`define RTP_OFF_BUF_LOW 3'h2
`define RTP_OFF_BUF_HIGH 3'h3
`define RTP_OFF_BIT_MODE 3'h4
`define RTP_OFF_CONTROL 3'h5

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define RTP_CTL_EXT_BIT 0
`define RTP_CTL_BYTE_BIT 1
`define RTP_CTL_MASK 8'h03

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RTP_RST_DIR 8'hFF
`define RTP_RST_BIT_MODE 8'h00
`define RTP_RST_CONTROL 8'h00
`define RTP_RST_ZERO 8'h00

`endif

// ---- hdl/rtp_pkg.sv ----
/*
  types of the real-time output port.
  assumes nothing beyond the defines header.
*/
package rtp_pkg;

  // ---------------------------------------------------------------
  // whole state of the port
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] oe;
    logic [7:0] buffer;
    logic [7:0] bit_mode;
    logic [7:0] control;
    logic [7:0] rdata;
  } rtp_state_t;

endpackage

// ---- hdl/rtp_realtime_output_port.sv ----
/*
  eight-bit real-time output port: buffer, trigger copy, port latch, sfr access.
  assumes a single-cycle sfr access port synchronous to ref_clk_i and
  one-cycle event pulses from the timer and external-interrupt blocks.
*/
`timescale 1ns/1ps
`include "rtp_defines.svh"

module rtp_realtime_output_port
  import rtp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [2:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic timer1_match_event_i,
  input wire logic timer2_match_event_i,
  input wire logic pin2_edge_event_i,
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // nibble mask from a select
  function automatic logic [3:0] nib(input logic sel);
    nib = sel ? 4'hF : 4'h0;
  endfunction

  rtp_state_t st_q;
  rtp_state_t st_d;
  logic byte_mode;
  logic external_trigger_select_bit;
  logic trig_hi;
  logic trig_lo;
  logic [7:0] copy_mask;
  logic wr_low;
  logic wr_high;

  // trigger selection from control register
  always_comb begin
    byte_mode = st_q.control[`RTP_CTL_BYTE_BIT];
    external_trigger_select_bit = st_q.control[`RTP_CTL_EXT_BIT];
    case ({byte_mode, external_trigger_select_bit})
      2'b00: begin
        trig_hi = timer2_match_event_i;
        trig_lo = timer1_match_event_i;
      end
      2'b01: begin
        trig_hi = timer1_match_event_i;
        trig_lo = pin2_edge_event_i;
      end
      2'b10: begin
        trig_hi = timer1_match_event_i;
        trig_lo = timer1_match_event_i;
      end
      2'b11: begin
        trig_hi = pin2_edge_event_i;
        trig_lo = pin2_edge_event_i;
      end
      default: begin
        trig_hi = 1'b0;
        trig_lo = 1'b0;
      end
    endcase
    // only real-time bits take the copy
    copy_mask = {nib(trig_hi), nib(trig_lo)} & st_q.bit_mode;
    wr_low = sfr_wr_i && (sfr_addr_i == `RTP_OFF_BUF_LOW);
    wr_high = sfr_wr_i && (sfr_addr_i == `RTP_OFF_BUF_HIGH);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // software write to the latch skips real-time bits
    if (sfr_wr_i && sfr_addr_i == `RTP_OFF_LATCH) begin
      st_d.latch = (st_q.latch & st_q.bit_mode) | (sfr_wdata_i & ~st_q.bit_mode);
    end
    // hardware copy from buffer to latch
    st_d.latch = (st_d.latch & ~copy_mask) | (st_q.buffer & copy_mask);
    if (sfr_wr_i && sfr_addr_i == `RTP_OFF_DIR) begin
      st_d.dir = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == `RTP_OFF_BIT_MODE) begin
      st_d.bit_mode = sfr_wdata_i;
    end
    if (sfr_wr_i && sfr_addr_i == `RTP_OFF_CONTROL) begin
      st_d.control = sfr_wdata_i & `RTP_CTL_MASK;
    end
    // buffer loads by mode
    if (byte_mode && (wr_low || wr_high)) begin
      st_d.buffer = sfr_wdata_i;
    end else if (wr_low) begin
      st_d.buffer[3:0] = sfr_wdata_i[3:0];
    end else if (wr_high) begin
      st_d.buffer[7:4] = sfr_wdata_i[7:4];
    end
    // pin drives only where direction is output
    st_d.oe = ~st_d.dir;
    // registered read data
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        `RTP_OFF_LATCH: st_d.rdata = (st_q.latch & ~st_q.dir) | (port_pin_i & st_q.dir);
        `RTP_OFF_DIR: st_d.rdata = st_q.dir;
        `RTP_OFF_BUF_LOW,
        `RTP_OFF_BUF_HIGH: st_d.rdata = st_q.buffer & st_q.bit_mode;
        `RTP_OFF_BIT_MODE: st_d.rdata = st_q.bit_mode;
        `RTP_OFF_CONTROL: st_d.rdata = st_q.control;
        default: st_d.rdata = `RTP_RST_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q.latch <= `RTP_RST_ZERO;
      st_q.dir <= `RTP_RST_DIR;
      st_q.oe <= `RTP_RST_ZERO;
      st_q.buffer <= `RTP_RST_ZERO;
      st_q.bit_mode <= `RTP_RST_BIT_MODE;
      st_q.control <= `RTP_RST_CONTROL;
      st_q.rdata <= `RTP_RST_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  assign sfr_rdata_o = st_q.rdata;
  assign port_pin_o = st_q.latch;
  assign port_pin_oe_o = st_q.oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence seq_byte_timer_trig;
    byte_mode && !external_trigger_select_bit && timer1_match_event_i;
  endsequence

  sequence seq_latch_quiet;
    !(sfr_wr_i && sfr_addr_i == `RTP_OFF_LATCH);
  endsequence

  chk_trig_copy: assert property (
    seq_byte_timer_trig |=> (st_q.latch & $past(st_q.bit_mode)) ==
      $past(st_q.buffer & st_q.bit_mode))
    else $error("timer1 trigger did not copy buffer in byte mode");

  chk_port_hold: assert property (
    (trig_hi || trig_lo) ##0 seq_latch_quiet |=>
      (st_q.latch & ~$past(st_q.bit_mode)) == $past(st_q.latch & ~st_q.bit_mode))
    else $error("trigger changed a port-mode latch bit");

  chk_latch_block: assert property (
    (sfr_wr_i && sfr_addr_i == `RTP_OFF_LATCH && !trig_hi && !trig_lo) |=>
      (st_q.latch & $past(st_q.bit_mode)) == $past(st_q.latch & st_q.bit_mode))
    else $error("software write reached a real-time latch bit");

  chk_nibble_low: assert property (
    (!byte_mode && wr_low) |=> st_q.buffer[7:4] == $past(st_q.buffer[7:4]) &&
      st_q.buffer[3:0] == $past(sfr_wdata_i[3:0]))
    else $error("low buffer write in 4x2 mode misbehaved");

  chk_nibble_high: assert property (
    (!byte_mode && wr_high) |=> st_q.buffer[3:0] == $past(st_q.buffer[3:0]) &&
      st_q.buffer[7:4] == $past(sfr_wdata_i[7:4]))
    else $error("high buffer write in 4x2 mode misbehaved");

  chk_dir_write: assert property (
    (sfr_wr_i && sfr_addr_i == `RTP_OFF_DIR) |=> st_q.dir == $past(sfr_wdata_i))
    else $error("direction register did not take write");

  chk_unmapped_read: assert property (
    (sfr_rd_i && sfr_addr_i > `RTP_OFF_CONTROL) |=> sfr_rdata_o == `RTP_RST_ZERO)
    else $error("unmapped read did not return zero");

  chk_byte_load: assert property (
    (byte_mode && (wr_low || wr_high)) |=> st_q.buffer == $past(sfr_wdata_i))
    else $error("byte mode buffer write did not load all bits");

  chk_read_mask: assert property (
    (sfr_rd_i && (sfr_addr_i == `RTP_OFF_BUF_LOW || sfr_addr_i == `RTP_OFF_BUF_HIGH))
      |=> sfr_rdata_o == $past(st_q.buffer & st_q.bit_mode))
    else $error("buffer read not masked by bit mode");

  chk_oe_dir: assert property (
    ##1 port_pin_oe_o == ~st_q.dir)
    else $error("pin enable disagrees with direction");

  chk_mode_write: assert property (
    (sfr_wr_i && sfr_addr_i == `RTP_OFF_BIT_MODE) |=> st_q.bit_mode == $past(sfr_wdata_i))
    else $error("bit mode register did not take write");

  chk_reset_vals: assert property (disable iff (1'b0)
    srst_i |=> st_q.dir == `RTP_RST_DIR && st_q.bit_mode == `RTP_RST_BIT_MODE &&
      st_q.control == `RTP_RST_CONTROL && port_pin_oe_o == `RTP_RST_ZERO)
    else $error("reset values wrong");

endmodule

// ---- dv/rtp_actuator_model.sv ----
/*
  stepping motor driver model on the eight shared port pins.
  assumes a per-pin enable that is high while the port drives the pin.
*/
`timescale 1ns/1ps

module rtp_actuator_model (
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] pin_oe_i,
  output logic [7:0] pin_level_o
);
  // ---------------------------------------------------------------
  // wire level
  // ---------------------------------------------------------------
  // lines the port does not drive float to the driver's pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level_o[i] = pin_oe_i[i] ? pin_o_i[i] : 1'b1;
    end
  end
endmodule

// ---- dv/test_rtp_realtime_output_port.sv ----
/*
  self-checking bench of the real-time output port.
  assumes the package, the defines header and the actuator model.
*/
`timescale 1ns/1ps
`include "rtp_defines.svh"

module test_rtp_realtime_output_port
  import rtp_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctl;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [2:0] ev;
    logic [7:0] buf_exp;
    logic [7:0] pin_exp;
  } rtp_row_t;
  // ev bits: 0 timer1, 1 timer2, 2 pin edge
  rtp_row_t rows [9] = '{
    '{8'h02, 3'h2, 8'h3C, 3'h1, 8'h3C, 8'h3C}, '{8'h02, 3'h3, 8'hA5, 3'h1, 8'hA5, 8'hA5},
    '{8'h03, 3'h2, 8'h96, 3'h4, 8'h96, 8'h96}, '{8'h03, 3'h3, 8'h0F, 3'h1, 8'h0F, 8'h96},
    '{8'h00, 3'h2, 8'hF1, 3'h1, 8'h01, 8'h91}, '{8'h00, 3'h3, 8'h7E, 3'h2, 8'h71, 8'h71},
    '{8'h01, 3'h2, 8'h3C, 3'h4, 8'h7C, 8'h7C}, '{8'h01, 3'h3, 8'h2B, 3'h1, 8'h2C, 8'h2C},
    '{8'h01, 3'h3, 8'h50, 3'h2, 8'h5C, 8'h2C}};
  logic clk = 1'b0;
  logic srst;
  logic [2:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] ev;
  logic [7:0] pin_i;
  logic [7:0] pin_o;
  logic [7:0] oe;
  int failures = 0;
  int samples_checked = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  rtp_realtime_output_port dut (.ref_clk_i(clk), .srst_i(srst), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .timer1_match_event_i(ev[0]), .timer2_match_event_i(ev[1]),
    .pin2_edge_event_i(ev[2]), .port_pin_i(pin_i), .port_pin_o(pin_o),
    .port_pin_oe_o(oe));

  rtp_actuator_model actuator (.pin_o_i(pin_o), .pin_oe_i(oe), .pin_level_o(pin_i));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // every access spends one idle cycle before its strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(rdata, exp);
  endtask

  task automatic pulse(input logic [2:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 3'h0;
  endtask

  task automatic reset_chk();
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    check(oe, 8'h00);
    rd_chk(`RTP_OFF_DIR, 8'hFF);
    rd_chk(`RTP_OFF_BIT_MODE, 8'h00);
    rd_chk(`RTP_OFF_CONTROL, 8'h00);
    $display("test reset done");
  endtask

  task automatic results();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    addr = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    ev = 3'h0;
    reset_chk();
    wr_reg(`RTP_OFF_LATCH, 8'h5A);
    wr_reg(`RTP_OFF_DIR, 8'h00);
    wr_reg(`RTP_OFF_BIT_MODE, 8'hFF);
    check(pin_o, 8'h5A);
    check(oe, 8'hFF);
    foreach (rows[i]) begin
      wr_reg(`RTP_OFF_CONTROL, rows[i].ctl);
      wr_reg(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr ^ 3'h1, rows[i].buf_exp);
      pulse(rows[i].ev);
      check(pin_o, rows[i].pin_exp);
    end
    // upper control bits are dropped, unmapped offsets read zero
    wr_reg(`RTP_OFF_CONTROL, 8'hFE);
    rd_chk(`RTP_OFF_CONTROL, 8'h02);
    rd_chk(3'h6, 8'h00);
    $display("test trigger table done");
    // half the bits back in port mode
    wr_reg(`RTP_OFF_CONTROL, 8'h02);
    wr_reg(`RTP_OFF_BIT_MODE, 8'h0F);
    wr_reg(`RTP_OFF_LATCH, 8'h00);
    check(pin_o, 8'h0C);
    wr_reg(`RTP_OFF_BUF_LOW, 8'hF3);
    rd_chk(`RTP_OFF_BUF_HIGH, 8'h03);
    pulse(3'h1);
    check(pin_o, 8'h03);
    wr_reg(`RTP_OFF_LATCH, 8'hFF);
    check(pin_o, 8'hF3);
    wr_reg(`RTP_OFF_DIR, 8'h0F);
    check(oe, 8'hF0);
    rd_chk(`RTP_OFF_LATCH, 8'hFF);
    rd_chk(`RTP_OFF_BIT_MODE, 8'h0F);
    $display("test mixed modes done");
    reset_chk();
    results();
  end
endmodule
